// >>> logic/kms_cfg.svh
// constants of the key matrix scanner: offsets, fields, resets, timing
// assumes one 32-bit apb slave window, 8-bit byte address
//
// Summary of operation
// - six scan lines by five returns, 30 keys
// - segment-use lines one and two zero ten keys
// - sleep ack keeps mode at key press
// - mode write during pending request updates ack
// - sleep bit blanks segment and common outputs
// - sleep halts time base except while scanning or pending
// - port outputs keep working in sleep
// - one scan lasts 288 base periods
// - two matching scans, request at 615 periods
// - scan lines follow level bits, low lines idle
// - key press starts scans until all released
// - chip enable high releases request output
// - key read clears request, starts new scan
// - press in sleep restarts time base, scans
// - key read in sleep keeps sleep mode
// - scan disable blocks every key scan
// - disable during scan aborts it at once
// - disable while pending clears keys and request
// - clearing disable bit re-enables scanning
// - reset clears keys, scanner to initial state
// - request stays released throughout reset
`ifndef KMS_CFG_SVH
`define KMS_CFG_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define KMS_OFF_CTRL  8'h00
`define KMS_OFF_KEYS  8'h04
`define KMS_OFF_STAT  8'h08

// -----------------------------------------------------------------
// control field positions
// -----------------------------------------------------------------
`define KMS_F_SLEEP   0
`define KMS_F_CLKSEL  1
`define KMS_F_DIS     2
`define KMS_F_SEG     3
`define KMS_F_LVL     8
`define KMS_F_PORT    16
`define KMS_F_SA      31
`define KMS_SEG_KEYS  2'b11

// -----------------------------------------------------------------
// reset values and timing in base periods
// -----------------------------------------------------------------
`define KMS_CTRL_RST  32'h0000_3f00
`define KMS_SCAN_T    288
`define KMS_REQ_T     615

`endif

// >>> logic/kms_pkg.sv
// types of the key matrix scanner
// assumes kms_cfg.svh holds the numeric constants
package kms_pkg;
    // scanner sequence states
    typedef enum logic [1:0] {
        KMS_IDLE,
        KMS_SCAN,
        KMS_HOLD
    } kms_state_e;
endpackage

// >>> logic/kms_scanner.sv
// key matrix scanner with apb register access
// assumes timebase, chip enable and return lines are asynchronous pins
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "kms_cfg.svh"

module kms_scanner #(
    parameter int N_SCAN = 6,
    parameter int N_RET  = 5
) (
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   timebase_pin,
    input  wire logic                   chip_enable,
    input  wire logic [N_RET-1:0]       return_line_inputs,
    output logic [N_SCAN-1:0]           scan_line_outputs,
    output logic                        req_n_o,
    output logic                        req_n_oe,
    output logic                        seg_com_off,
    output logic [3:0]                  port_output_bits,
    output logic                        osc_run,
    output logic                        ext_clk_accept,
    output kms_pkg::kms_state_e         scan_state
);
    import kms_pkg::*;

    // -------------------------------------------------------------
    // derived sizes
    // -------------------------------------------------------------
    localparam int NK   = N_SCAN * N_RET;         // key count
    localparam int SLOT = `KMS_SCAN_T / N_SCAN;   // periods per line
    localparam int NS   = N_RET + 2;              // synced pins

    // refuse shapes the logic cannot serve
    if (N_SCAN < 3 || NK > 31 || SLOT * N_SCAN != `KMS_SCAN_T
        || SLOT > 63 || N_SCAN > 8) begin : g_chk
        $error("kms_scanner: unsupported matrix shape");
    end

    localparam logic [9:0] SCAN_T = 10'(`KMS_SCAN_T);
    localparam logic [9:0] REQ_T  = 10'(`KMS_REQ_T);
    localparam logic [5:0] SLOT_L = 6'(SLOT - 1);
    localparam logic [2:0] LINE_L = 3'(N_SCAN - 1);

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    logic [NS-1:0] s1_q;     // first stage, read by s2 only
    logic [NS-1:0] s2_q;     // second stage
    logic [NS-1:0] s3_q;     // third stage
    logic [NS-1:0] flt_q;    // accepted level
    logic          tb_prev_q;

    // three stages, level taken once stages two and three agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end else begin
            s1_q  <= {chip_enable, timebase_pin, return_line_inputs};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
        end
    end

    logic [N_RET-1:0] ret_f;   // filtered return lines
    logic             tb_f;    // filtered time base
    logic             ce_f;    // filtered chip enable
    assign ret_f = flt_q[N_RET-1:0];
    assign tb_f  = flt_q[N_RET];
    assign ce_f  = flt_q[N_RET+1];

    // -------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------
    logic [31:0]      ctrl_q;     // control word
    logic [NK-1:0]    keys_q;     // confirmed key bits
    logic             sa_q;       // sleep ack bit
    kms_state_e       st_q;       // scanner state
    logic             acc;        // access phase
    logic             wr_ctrl;    // control write taken
    logic             key_rd;     // key word read taken
    logic             hit;        // mapped offset
    logic [31:0]      key_word;   // key read value
    logic [31:0]      stat_word;  // status read value

    assign acc     = psel & penable;
    assign hit     = (paddr == `KMS_OFF_CTRL) || (paddr == `KMS_OFF_KEYS)
                     || (paddr == `KMS_OFF_STAT);
    assign wr_ctrl = acc & pwrite & (paddr == `KMS_OFF_CTRL);
    assign key_rd  = acc & ~pwrite & (paddr == `KMS_OFF_KEYS);
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;

    // assemble read words
    always_comb begin
        key_word              = '0;
        key_word[NK-1:0]      = keys_q;
        key_word[`KMS_F_SA]   = sa_q;
        stat_word             = '0;
        stat_word[0]          = (st_q == KMS_HOLD);
        stat_word[1]          = (st_q == KMS_SCAN);
        stat_word[2]          = osc_run | ext_clk_accept;
    end

    // read data captured in the setup cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `KMS_OFF_CTRL: prdata <= ctrl_q;
                `KMS_OFF_KEYS: prdata <= key_word;
                `KMS_OFF_STAT: prdata <= stat_word;
                default:       prdata <= '0;
            endcase
        end
    end

    // control word, written whole
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `KMS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata;
        end
    end

    // control fields
    logic              sleep;    // sleep request
    logic              clksel;   // external clock chosen
    logic              dis;      // scan disable
    logic              seg_on;   // first two lines as segments
    logic [N_SCAN-1:0] eff_lvl;  // usable high-held lines
    assign sleep   = ctrl_q[`KMS_F_SLEEP];
    assign clksel  = ctrl_q[`KMS_F_CLKSEL];
    assign dis     = ctrl_q[`KMS_F_DIS];
    assign seg_on  = ctrl_q[`KMS_F_SEG +: 2] == `KMS_SEG_KEYS;
    assign eff_lvl = ctrl_q[`KMS_F_LVL +: N_SCAN]
                     & ~(seg_on ? N_SCAN'(3) : '0);

    // mode outputs straight from the control word
    assign seg_com_off      = sleep;
    assign port_output_bits = ctrl_q[`KMS_F_PORT +: 4];

    // -------------------------------------------------------------
    // time base gating and period tick
    // -------------------------------------------------------------
    logic press;    // key down on a high-held line
    logic tb_run;   // time base needed
    logic tick;     // one base period elapsed

    assign press  = (|ret_f) & (|eff_lvl) & ~dis;
    assign tb_run = ~sleep | (st_q != KMS_IDLE) | press;
    assign tick   = tb_f & ~tb_prev_q & tb_run;

    // edge memory and source enables
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tb_prev_q      <= 1'b0;
            osc_run        <= 1'b0;
            ext_clk_accept <= 1'b0;
        end else begin
            tb_prev_q      <= tb_f;
            osc_run        <= tb_run & ~clksel;
            ext_clk_accept <= tb_run & clksel;
        end
    end

    // -------------------------------------------------------------
    // scan sequencer
    // -------------------------------------------------------------
    logic [9:0]        cnt_q;    // periods since scan start
    logic [5:0]        slot_q;   // period within line slot
    logic [2:0]        line_q;   // active scan line
    logic              pass_q;   // second scan in progress
    logic [NK-1:0]     res0_q;   // first scan result
    logic [NK-1:0]     res1_q;   // second scan result
    logic              in_scan;  // lines still being driven
    logic              last;     // decision period reached
    logic              agree;    // both scans match, nonzero

    assign in_scan = cnt_q < (SCAN_T + SCAN_T);
    assign last    = tick && (st_q == KMS_SCAN) && (cnt_q == REQ_T - 10'd1);
    assign agree   = (res0_q == res1_q) && (|res1_q);
    assign scan_state = st_q;

    // state, counters and key buffer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q   <= KMS_IDLE;
            cnt_q  <= '0;
            slot_q <= '0;
            line_q <= '0;
            pass_q <= 1'b0;
            keys_q <= '0;
            sa_q   <= 1'b0;
        end else if (dis) begin
            // abort any scan, drop a pending request
            st_q <= KMS_IDLE;
            if (st_q == KMS_HOLD) begin
                keys_q <= '0;
            end
        end else begin
            case (st_q)
                KMS_IDLE: begin
                    // press on a high-held line starts scanning
                    if (press) begin
                        st_q   <= KMS_SCAN;
                        sa_q   <= sleep;
                        cnt_q  <= '0;
                        slot_q <= '0;
                        line_q <= '0;
                        pass_q <= 1'b0;
                    end
                end
                KMS_SCAN: begin
                    if (last) begin
                        // decide after two scans
                        cnt_q  <= '0;
                        slot_q <= '0;
                        line_q <= '0;
                        pass_q <= 1'b0;
                        if (agree) begin
                            st_q   <= KMS_HOLD;
                            keys_q <= res1_q;
                        end else if (!(|res1_q)) begin
                            st_q <= KMS_IDLE;
                        end
                    end else if (tick) begin
                        cnt_q <= cnt_q + 10'd1;
                        if (in_scan) begin
                            if (slot_q == SLOT_L) begin
                                slot_q <= '0;
                                line_q <= (line_q == LINE_L) ? 3'd0
                                          : line_q + 3'd1;
                                if (line_q == LINE_L) begin
                                    pass_q <= 1'b1;
                                end
                            end else begin
                                slot_q <= slot_q + 6'd1;
                            end
                        end
                    end
                end
                KMS_HOLD: begin
                    // mode change while pending updates the ack
                    if (wr_ctrl) begin
                        sa_q <= pwdata[`KMS_F_SLEEP];
                    end
                    // controller read clears request, scan again
                    if (key_rd) begin
                        st_q   <= KMS_SCAN;
                        cnt_q  <= '0;
                        slot_q <= '0;
                        line_q <= '0;
                        pass_q <= 1'b0;
                        sa_q   <= sleep;
                    end
                end
                default: st_q <= KMS_IDLE;
            endcase
        end
    end

    // per-key capture at the end of each line slot
    for (genvar i = 0; i < NK; i++) begin : g_key
        localparam logic [2:0] LN = 3'(i / N_RET);
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                res0_q[i] <= 1'b0;
                res1_q[i] <= 1'b0;
            end else if (st_q == KMS_SCAN && tick && in_scan
                         && slot_q == SLOT_L && line_q == LN) begin
                // key bit set when its return is high
                if (pass_q) begin
                    res1_q[i] <= ret_f[i % N_RET] & eff_lvl[LN];
                end else begin
                    res0_q[i] <= ret_f[i % N_RET] & eff_lvl[LN];
                end
            end
        end
    end

    // scan line drive: pulse active line, else hold levels
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scan_line_outputs <= '0;
        end else if (st_q == KMS_SCAN && in_scan) begin
            scan_line_outputs <= (N_SCAN'(1) << line_q) & eff_lvl;
        end else begin
            scan_line_outputs <= eff_lvl;
        end
    end

    // -------------------------------------------------------------
    // open-drain request output
    // -------------------------------------------------------------
    assign req_n_o  = 1'b0;
    assign req_n_oe = (st_q == KMS_HOLD) & ~ce_f;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_req_src;
        req_n_oe |-> st_q == KMS_HOLD && keys_q != '0;
    endproperty
    a_req_src: assert property (p_req_src) else $error("request without keys");

    property p_ce;
        ce_f |-> !req_n_oe;
    endproperty
    a_ce: assert property (p_ce) else $error("request with ce high");

    property p_abort;
        (wr_ctrl && pwdata[`KMS_F_DIS]) |=> ##1 st_q == KMS_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("scan not aborted");

    property p_dis_clr;
        (st_q == KMS_HOLD && dis) |=> keys_q == '0 && !req_n_oe;
    endproperty
    a_dis_clr: assert property (p_dis_clr) else $error("keys not cleared");

    property p_seg;
        (last && seg_on) |=> keys_q[2*N_RET-1:0] == '0;
    endproperty
    a_seg: assert property (p_seg) else $error("segment keys set");

    property p_grant;
        (last && agree && !dis) |=> st_q == KMS_HOLD;
    endproperty
    a_grant: assert property (p_grant) else $error("agree not granted");

    property p_rd;
        (st_q == KMS_HOLD && key_rd && !dis) |=> st_q == KMS_SCAN
            && $stable(sleep);
    endproperty
    a_rd: assert property (p_rd) else $error("read did not rescan");

    property p_nodis;
        (dis && st_q == KMS_IDLE) |=> st_q == KMS_IDLE;
    endproperty
    a_nodis: assert property (p_nodis) else $error("scan while disabled");

    property p_lines;
        (st_q != KMS_IDLE) |-> ##1 (scan_line_outputs & ~$past(eff_lvl)) == '0;
    endproperty
    a_lines: assert property (p_lines) else $error("pulse on low line");

    property p_gate;
        (sleep && st_q == KMS_IDLE && !press) |=> !osc_run && !ext_clk_accept;
    endproperty
    a_gate: assert property (p_gate) else $error("time base runs in sleep");

    property p_sa;
        (st_q == KMS_IDLE && press && !dis) |=> sa_q == $past(sleep);
    endproperty
    a_sa: assert property (p_sa) else $error("sleep ack wrong");

    c_grant:  cover property (last && agree);
    c_rescan: cover property (last && !agree && |res1_q);
    c_abort:  cover property (st_q == KMS_SCAN && dis);
    c_ce:     cover property (st_q == KMS_HOLD && ce_f);

endmodule

// >>> tb/kms_key_matrix.sv
// key matrix model: switches between scan lines and return lines
// assumes scan lines drive high to select a row; open returns pull low
`timescale 1ns/10ps

module kms_key_matrix (
    input  wire logic [5:0]  scan_line_outputs,
    input  wire logic [29:0] pressed,
    output logic      [4:0]  return_line_inputs
);
    // -----------------------------------------------------------------
    // contact network
    // -----------------------------------------------------------------
    // closed switch copies its scan line onto its return
    always_comb begin
        return_line_inputs = 5'h00;
        for (int s = 0; s < 6; s++) begin
            for (int r = 0; r < 5; r++) begin
                // bit index is line times five plus return
                if (pressed[s * 5 + r] && scan_line_outputs[s]) begin
                    return_line_inputs[r] = 1'b1;
                end
            end
        end
    end
endmodule

// >>> tb/tb_kms_scanner.sv
// testbench of the key matrix scanner: apb master, key matrix, checks
// assumes kms_pkg and kms_cfg.svh are compiled before this file
`timescale 1ns/10ps
`include "kms_cfg.svh"

module tb_kms_scanner;
    import kms_pkg::*;
    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    logic        mclk, timebase_pin;            // system and base clocks
    logic        nrst = 1'b0;                    // reset, low at start
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;                     // read data, last taken
    logic        pready, pslverr, err;
    logic        chip_enable = 1'b0;             // serial chip enable
    logic [4:0]  return_line_inputs;
    logic [5:0]  scan_line_outputs;
    logic [29:0] keys = 30'h0000_0000;           // pressed switches
    logic        req_n_o, req_n_oe, seg_com_off, osc_run, ext_clk_accept;
    logic [3:0]  port_output_bits;
    kms_state_e  scan_state;
    logic        scanning, idle;                 // decoded scanner state
    int          failures = 0, checks_done = 0, n;
    // request line with its pull-up
    wire         req_line = req_n_oe ? req_n_o : 1'b1;
    // ctrl word beside {seg off, port, osc run, ext accept, scan lines}
    logic [31:0] row_ctrl [5] = '{32'h0000_3f00, 32'h0005_3f01, 32'h000a_3f02,
                                  32'h000f_3f03, 32'h0000_2a00};
    logic [12:0] row_exp  [5] = '{13'h00bf, 13'h153f, 13'h0a7f, 13'h1f3f, 13'h00aa};

    always_comb scanning = (scan_state == KMS_SCAN);
    always_comb idle = (scan_state == KMS_IDLE);

    // -----------------------------------------------------------------
    // clocks and parts
    // -----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // base period clock, unrelated in phase
    initial begin
        timebase_pin = 1'b0;
        forever #62.5 timebase_pin = ~timebase_pin;
    end

    kms_scanner uut (.mclk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .timebase_pin, .chip_enable,
        .return_line_inputs, .scan_line_outputs, .req_n_o, .req_n_oe,
        .seg_com_off, .port_output_bits, .osc_run, .ext_clk_accept, .scan_state);

    kms_key_matrix matrix (.scan_line_outputs, .pressed(keys), .return_line_inputs);

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    // one apb transfer; answer taken at the edge with pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // wait for a level under a bounded count, n holds the cycles
    task automatic wait_for(input string nm, ref logic sig, input logic lvl, input int lim);
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(posedge mclk);
            n++;
        end
        chk(nm, lvl, sig);
    endtask

    // press keys, time the request from the start of the scan
    task automatic press(input logic [29:0] k);
        @(posedge mclk);
        keys <= k;
        wait_for("scan start", scanning, 1'b1, 300);
        wait_for("request", req_n_oe, 1'b1, 12000);
        chk("request delay", 1, n > 9570 && n < 9650);
    endtask

    // release keys, read key word while request pending
    task automatic read_keys(input logic [31:0] exp);
        @(posedge mclk);
        keys <= 30'h0000_0000;
        chk("request before read", 1, req_n_oe);
        apb(1'b0, `KMS_OFF_KEYS, 32'h0000_0000);
        chk("key word", exp, rd);
        if ($countones(rd[29:0]) > 2) rd = 32'h0000_0000;
        repeat (2) @(posedge mclk);
        chk("request cleared", 0, req_n_oe);
        chk("rescan", 1, scanning);
        wait_for("idle", idle, 1'b1, 12000);
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic stop_test();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        chk("request in reset", 0, req_n_oe);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, `KMS_OFF_CTRL, 32'h0000_0000);
        chk("ctrl reset", `KMS_CTRL_RST, rd);
        apb(1'b0, `KMS_OFF_KEYS, 32'h0000_0000);
        chk("keys reset", 0, rd);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk("unmapped error", 1, err);
        done("reset");
        // control rows: sleep, clock source, ports, line levels
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `KMS_OFF_CTRL, row_ctrl[i]);
            repeat (4) @(posedge mclk);
            chk("outputs", row_exp[i], {seg_com_off, port_output_bits, osc_run,
                ext_clk_accept, scan_line_outputs});
        end
        done("control rows");
        // normal press, chip enable release
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f00);
        press(30'h0000_2000);
        chk("request line", 0, req_line);
        apb(1'b0, `KMS_OFF_STAT, 32'h0000_0000);
        chk("status pending", 32'h0000_0005, rd);
        chip_enable <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("ce release", 0, req_n_oe);
        chip_enable <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("ce restore", 1, req_n_oe);
        read_keys(32'h0000_2000);
        done("normal press");
        // sleep with lines one and two as segments
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f19);
        press(30'h0004_0004);
        chk("time base in sleep scan", 1, osc_run);
        read_keys(32'h8004_0000);
        chk("still asleep", 1, seg_com_off);
        done("sleep press");
        // mode written while pending
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f00);
        press(30'h0000_0001);
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f01);
        read_keys(32'h8000_0001);
        done("mode while pending");
        // scan disable while pending, held, cleared, mid scan
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f00);
        press(30'h2000_0000);
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f04);
        repeat (3) @(posedge mclk);
        chk("disable release", 0, req_n_oe);
        apb(1'b0, `KMS_OFF_KEYS, 32'h0000_0000);
        chk("disable keys", 0, rd[29:0]);
        repeat (1000) @(posedge mclk);
        chk("no scan", 1, idle);
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f00);
        wait_for("re-enabled", scanning, 1'b1, 300);
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f04);
        wait_for("abort", idle, 1'b1, 4);
        done("scan disable");
        // reset in mid-run while a request is pending
        apb(1'b1, `KMS_OFF_CTRL, 32'h0000_3f00);
        wait_for("pending again", req_n_oe, 1'b1, 12000);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("request in mid reset", 0, req_n_oe);
        apb(1'b0, `KMS_OFF_KEYS, 32'h0000_0000);
        chk("request line in reset", 1, req_line);
        nrst <= 1'b1;
        apb(1'b0, `KMS_OFF_KEYS, 32'h0000_0000);
        chk("keys after reset", 0, rd);
        keys <= 30'h0000_0000;
        done("mid-run reset");
        stop_test();
    end

    // hang guard, beyond the longest expected run
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        stop_test();
    end
endmodule
